// >>> hw/mcpt_pkg.sv
// shared constants for the timer event and pin layer
package mcpt_pkg;
  localparam int unsigned MCPT_NUM_CH     = 3;
  localparam int unsigned MCPT_CH0_GRS    = 4;
  localparam int unsigned MCPT_CH12_GRS   = 2;
  localparam int unsigned MCPT_NUM_EXTCLK = 4;
  localparam int unsigned MCPT_CH0_IRQS   = 5;
  localparam int unsigned MCPT_CH12_IRQS  = 4;
  localparam int unsigned MCPT_SYNC_STAGES = 2;
  // bit positions of the external clock inputs
  localparam int unsigned MCPT_EXT_A = 0;
  localparam int unsigned MCPT_EXT_B = 1;
  localparam int unsigned MCPT_EXT_C = 2;
  localparam int unsigned MCPT_EXT_D = 3;
  // interrupt vector layout, channel 0
  localparam int unsigned MCPT_IRQ0_OVF = 4;
  // interrupt vector layout, channels 1 and 2
  localparam int unsigned MCPT_IRQ_GRA  = 0;
  localparam int unsigned MCPT_IRQ_GRB  = 1;
  localparam int unsigned MCPT_IRQ_OVF  = 2;
  localparam int unsigned MCPT_IRQ_UNF  = 3;
  // reset values
  localparam logic [3:0] MCPT_EXT_RST  = 4'h0;
  localparam logic [7:0] MCPT_PIN_RST  = 8'h00;
  // pin modes
  typedef enum logic [1:0] {
    MCPT_PIN_CAPTURE,
    MCPT_PIN_COMPARE,
    MCPT_PIN_PWM,
    MCPT_PIN_OFF
  } mcpt_pin_mode_t;
endpackage

// >>> hw/mcpt_sync.sv
// two-stage synchroniser for a vector of pin inputs
module mcpt_sync #(
  parameter int unsigned WIDTH = 1
) (
  // clock and reset
  input  wire logic             i_ref_clk,
  input  wire logic             i_rst,
  // pin side
  input  wire logic [WIDTH-1:0] i_async,
  // synchronised side
  output logic      [WIDTH-1:0] o_sync
);
  logic [WIDTH-1:0] meta;

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      meta   <= '0;
      o_sync <= '0;
    end else begin
      meta   <= i_async;
      o_sync <= meta;
    end
  end
endmodule // mcpt_sync

// >>> hw/mcpt_event_pins.sv
// event routing and pin layer of the three-channel pulse timer
// Function
// - each channel requests a transfer-controller start on any general register match or capture.
// - each channel requests a dma start only on a register A match or capture.
// - each channel triggers an a/d conversion on a register A match or capture.
// - channel 1 raises four interrupt sources: reg A, reg B, overflow, underflow.
// - channel 2 raises four interrupt sources: reg A, reg B, overflow, underflow.
// - four shared external clock inputs A to D each can be a counting clock.
// - in phase mode channel 1 uses clock A as phase A and clock B as phase B.
// - in phase mode channel 2 uses clock C as phase A and clock D as phase B.
// - each timer pin serves its register as capture input, compare output or pwm output.
// - channel 0 has four pins A to D, channels 1 and 2 two pins A and B each.
module mcpt_event_pins
  import mcpt_pkg::*;
(
  // clock and reset
  input  wire logic                 i_ref_clk,
  input  wire logic                 i_rst,
  // general register match or capture events, one cycle each
  input  wire logic [3:0]           i_ch0_gr_event,
  input  wire logic [1:0]           i_ch1_gr_event,
  input  wire logic [1:0]           i_ch2_gr_event,
  // counter overflow and underflow pulses
  input  wire logic [2:0]           i_ovf,
  input  wire logic [2:1]           i_unf,
  // per-pin mode and compare/pwm levels, order ch0 a..d, ch1 a b, ch2 a b
  input  mcpt_pkg::mcpt_pin_mode_t  i_pin_mode [8],
  input  wire logic [7:0]           i_pin_level,
  // phase counting mode enables for channels 1 and 2
  input  wire logic [2:1]           i_phase_mode,
  // external clock pins
  input  wire logic                 i_ext_clock_in_a,
  input  wire logic                 i_ext_clock_in_b,
  input  wire logic                 i_ext_clock_in_c,
  input  wire logic                 i_ext_clock_in_d,
  // two-way timer pins
  input  wire logic [7:0]           i_pin,
  output logic      [7:0]           o_pin,
  output logic      [7:0]           o_pin_oe,
  // synchronised pin levels for capture logic
  output logic      [7:0]           o_capture_level,
  // synchronised external clocks, for counting clock selection
  output logic      [3:0]           o_ext_clock,
  // phase inputs, channels 1 and 2
  output logic      [2:1]           o_phase_a,
  output logic      [2:1]           o_phase_b,
  // requests to transfer controllers and converter, one cycle pulses
  output logic      [2:0]           o_dtc_req,
  output logic      [2:0]           o_dma_req,
  output logic      [2:0]           o_adc_trig,
  // interrupt source pulses
  output logic      [4:0]           o_ch0_irq,
  output logic      [3:0]           o_ch1_irq,
  output logic      [3:0]           o_ch2_irq
);
  import mcpt_pkg::*;

  logic [3:0] ext_raw;
  logic [3:0] ext_sync;
  logic [7:0] pin_sync;

  function automatic logic any_event(input logic [3:0] ev);
    return |ev;
  endfunction

  assign ext_raw = {i_ext_clock_in_d, i_ext_clock_in_c, i_ext_clock_in_b, i_ext_clock_in_a};

  // pins are asynchronous, so both groups pass two flops first
  mcpt_sync #(.WIDTH(MCPT_NUM_EXTCLK)) u_ext_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (ext_raw),
    .o_sync    (ext_sync)
  );

  mcpt_sync #(.WIDTH(8)) u_pin_sync (
    .i_ref_clk (i_ref_clk),
    .i_rst     (i_rst),
    .i_async   (i_pin),
    .o_sync    (pin_sync)
  );

  // event decode
  wire [2:0] next_dtc_req;
  wire [2:0] next_dma_req;
  wire [4:0] next_ch0_irq;
  wire [3:0] next_ch1_irq;
  wire [3:0] next_ch2_irq;

  assign next_dtc_req = {any_event({2'h0, i_ch2_gr_event}),
                         any_event({2'h0, i_ch1_gr_event}),
                         any_event(i_ch0_gr_event)};
  assign next_dma_req = {i_ch2_gr_event[0], i_ch1_gr_event[0], i_ch0_gr_event[0]};
  assign next_ch0_irq = {i_ovf[0], i_ch0_gr_event};
  assign next_ch1_irq = {i_unf[1], i_ovf[1], i_ch1_gr_event};
  assign next_ch2_irq = {i_unf[2], i_ovf[2], i_ch2_gr_event};

  // pin drivers: a pin drives only in compare or pwm mode
  wire [7:0] next_pin_oe;
  wire [7:0] next_capture;
  for (genvar p = 0; p < 8; p++) begin : g_pin
    assign next_pin_oe[p]  = (i_pin_mode[p] == MCPT_PIN_COMPARE) ||
                             (i_pin_mode[p] == MCPT_PIN_PWM);
    assign next_capture[p] = (i_pin_mode[p] == MCPT_PIN_CAPTURE) & pin_sync[p];
  end

  // registered outputs keep data lines glitch free toward the far blocks
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_dtc_req  <= 3'h0;
      o_dma_req  <= 3'h0;
      o_adc_trig <= 3'h0;
      o_ch0_irq  <= 5'h00;
      o_ch1_irq  <= 4'h0;
      o_ch2_irq  <= 4'h0;
    end else begin
      o_dtc_req  <= next_dtc_req;
      o_dma_req  <= next_dma_req;
      o_adc_trig <= next_dma_req;
      o_ch0_irq  <= next_ch0_irq;
      o_ch1_irq  <= next_ch1_irq;
      o_ch2_irq  <= next_ch2_irq;
    end
  end

  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) begin
      o_pin           <= MCPT_PIN_RST;
      o_pin_oe        <= MCPT_PIN_RST;
      o_capture_level <= MCPT_PIN_RST;
    end else begin
      o_pin           <= i_pin_level & next_pin_oe;
      o_pin_oe        <= next_pin_oe;
      o_capture_level <= next_capture;
    end
  end

  // external clocks stay visible even in phase mode; selection is elsewhere
  assign o_ext_clock = ext_sync;
  assign o_phase_a   = {ext_sync[MCPT_EXT_C], ext_sync[MCPT_EXT_A]} & i_phase_mode;
  assign o_phase_b   = {ext_sync[MCPT_EXT_D], ext_sync[MCPT_EXT_B]} & i_phase_mode;
endmodule // mcpt_event_pins

// >>> verification/mcpt_event_pins_props.sv
// assertions on the event routing and phase outputs
module mcpt_event_pins_props
  import mcpt_pkg::*;
(
  // clock, reset and events
  input wire logic       i_ref_clk,
  input wire logic       i_rst,
  input wire logic [3:0] i_ch0_gr_event,
  input wire logic [1:0] i_ch1_gr_event,
  input wire logic [1:0] i_ch2_gr_event,
  input wire logic [2:0] i_ovf,
  input wire logic [2:1] i_unf,
  input wire logic [2:1] i_phase_mode,
  // design outputs
  input wire logic [3:0] o_ext_clock,
  input wire logic [2:1] o_phase_a,
  input wire logic [2:1] o_phase_b,
  input wire logic [2:0] o_dtc_req,
  input wire logic [2:0] o_dma_req,
  input wire logic [2:0] o_adc_trig,
  input wire logic [4:0] o_ch0_irq,
  input wire logic [3:0] o_ch1_irq,
  input wire logic [3:0] o_ch2_irq
);
  default clocking @(posedge i_ref_clk); endclocking
  default disable iff (i_rst);
  sequence s_lone_a;
    i_ch1_gr_event == 2'h1 ##1 i_ch1_gr_event == 2'h0;
  endsequence
  a_dtc_any_reg: assert property (o_dtc_req == $past({|i_ch2_gr_event, |i_ch1_gr_event,
    |i_ch0_gr_event})) else $error("transfer request wrong");
  a_dma_reg_a: assert property (o_dma_req == $past({i_ch2_gr_event[0], i_ch1_gr_event[0],
    i_ch0_gr_event[0]})) else $error("dma request wrong");
  a_dma_one_pulse: assert property (s_lone_a |-> o_dma_req[1] ##1 !o_dma_req[1])
    else $error("dma pulse length wrong");
  a_adc_with_dma: assert property (o_adc_trig == o_dma_req) else $error("a/d trigger wrong");
  a_ch0_irq_map: assert property (o_ch0_irq == $past({i_ovf[0], i_ch0_gr_event}))
    else $error("channel 0 interrupt wrong");
  a_ch1_irq_map: assert property (o_ch1_irq == $past({i_unf[1], i_ovf[1], i_ch1_gr_event}))
    else $error("channel 1 interrupt wrong");
  a_ch2_irq_map: assert property (o_ch2_irq == $past({i_unf[2], i_ovf[2], i_ch2_gr_event}))
    else $error("channel 2 interrupt wrong");
  a_phase_pin_map: assert property ({o_phase_b, o_phase_a} == ({o_ext_clock[3],
    o_ext_clock[1], o_ext_clock[2], o_ext_clock[0]} & {2{i_phase_mode}})) else $error("phase wrong");
endmodule // mcpt_event_pins_props
bind mcpt_event_pins mcpt_event_pins_props u_props (.i_ref_clk, .i_rst, .i_ch0_gr_event,
  .i_ch1_gr_event, .i_ch2_gr_event, .i_ovf, .i_unf, .i_phase_mode, .o_ext_clock, .o_phase_a,
  .o_phase_b, .o_dtc_req, .o_dma_req, .o_adc_trig, .o_ch0_irq, .o_ch1_irq, .o_ch2_irq);

// >>> verification/mcpt_partner.sv
// receiving controller model: counts request pulses per channel
module mcpt_partner (
  input  wire logic       i_ref_clk,
  input  wire logic       i_rst,
  input  wire logic [2:0] i_req,
  output int              o_count [3]
);
  timeunit 1ns;
  timeprecision 1ps;
  always_ff @(posedge i_ref_clk or posedge i_rst) begin
    if (i_rst) o_count <= '{default: 0};
    else for (int k = 0; k < 3; k++) o_count[k] <= o_count[k] + int'(i_req[k]);
  end
endmodule // mcpt_partner

// >>> verification/mcpt_event_pins_tb.sv
// self-checking bench for the timer event and pin layer
`define CHK(a, e) begin samples_checked++; if ((a) !== (e)) begin err_count++; \
  $display("BAD %0t mismatch", $time); end end
module mcpt_event_pins_tb;
  import mcpt_pkg::*;
  timeunit 1ns;
  timeprecision 1ps;
  logic           i_ref_clk = 1'h0, i_rst = 1'h1, i_ext_clock_in_a = 1'h0, i_ext_clock_in_b = 1'h0;
  logic           i_ext_clock_in_c = 1'h0, i_ext_clock_in_d = 1'h0;
  logic [3:0]     i_ch0_gr_event = '0, o_ext_clock;
  logic [1:0]     i_ch1_gr_event = '0, i_ch2_gr_event = '0;
  logic [2:0]     i_ovf = '0, o_dtc_req, o_dma_req, o_adc_trig;
  logic [2:1]     i_unf = '0, i_phase_mode = '0, o_phase_a, o_phase_b;
  logic [7:0]     i_pin_level = '0, i_pin = '0, o_pin, o_pin_oe, o_capture_level;
  logic [4:0]     o_ch0_irq;
  logic [3:0]     o_ch1_irq, o_ch2_irq;
  mcpt_pin_mode_t i_pin_mode [8] = '{default: MCPT_PIN_OFF};
  int             err_count = 0, samples_checked = 0, cnt_dtc [3], cnt_dma [3];
  always #2.5 i_ref_clk = ~i_ref_clk;
  mcpt_event_pins dut (.i_ref_clk, .i_rst, .i_ch0_gr_event, .i_ch1_gr_event, .i_ch2_gr_event,
    .i_ovf, .i_unf, .i_pin_mode, .i_pin_level, .i_phase_mode, .i_ext_clock_in_a,
    .i_ext_clock_in_b, .i_ext_clock_in_c, .i_ext_clock_in_d, .i_pin, .o_pin, .o_pin_oe,
    .o_capture_level, .o_ext_clock, .o_phase_a, .o_phase_b, .o_dtc_req, .o_dma_req,
    .o_adc_trig, .o_ch0_irq, .o_ch1_irq, .o_ch2_irq);
  mcpt_partner u_dtc (.i_ref_clk, .i_rst, .i_req(o_dtc_req), .o_count(cnt_dtc));
  mcpt_partner u_dma (.i_ref_clk, .i_rst, .i_req(o_dma_req), .o_count(cnt_dma));
  // one event cycle, then idle; outputs settled on return
  task automatic ev(input logic [12:0] v);
    @(posedge i_ref_clk);
    {i_ch0_gr_event, i_ch1_gr_event, i_ch2_gr_event, i_ovf, i_unf} <= v;
    @(posedge i_ref_clk);
    {i_ch0_gr_event, i_ch1_gr_event, i_ch2_gr_event, i_ovf, i_unf} <= '0;
    #1;
  endtask
  task automatic t_ch0();
    for (int i = 0; i < 4; i++) begin
      ev({4'h1 << i, 9'h000});
      `CHK(o_dtc_req, 3'h1)
      `CHK(o_dma_req, {2'h0, i == 0})
      `CHK(o_adc_trig, {2'h0, i == 0})
      `CHK(o_ch0_irq, 5'h01 << i)
    end
    ev(13'h0004);
    `CHK(o_ch0_irq, 5'h10)
    `CHK(o_dtc_req, 3'h0)
  endtask
  task automatic t_ch12();
    ev({4'h0, 2'h1, 2'h2, 3'h6, 2'h3});
    `CHK(o_dtc_req, 3'h6)
    `CHK(o_adc_trig, 3'h2)
    `CHK(o_ch1_irq, 4'hD)
    `CHK(o_ch2_irq, 4'hE)
    @(posedge i_ref_clk);
    #1;
    `CHK(o_dma_req, 3'h0)
    `CHK(cnt_dtc[0], 32'h4)
    `CHK(cnt_dma[1], 32'h1)
    `CHK(cnt_dma[2], 32'h0)
  endtask
  task automatic t_pins();
    @(posedge i_ref_clk);
    {i_ext_clock_in_d, i_ext_clock_in_c, i_ext_clock_in_b, i_ext_clock_in_a} <= 4'h5;
    i_phase_mode <= 2'h3;
    i_pin_mode[0] <= MCPT_PIN_COMPARE;
    i_pin_mode[1] <= MCPT_PIN_PWM;
    i_pin_mode[2] <= MCPT_PIN_CAPTURE;
    i_pin_level <= 8'hFF;
    i_pin <= 8'hFF;
    repeat (4) @(posedge i_ref_clk);
    #1;
    `CHK({o_ext_clock, o_phase_a, o_phase_b}, 8'h5C)
    `CHK({o_pin_oe, o_pin}, 16'h0303)
    `CHK(o_capture_level, 8'h04)
    @(posedge i_ref_clk);
    {i_ext_clock_in_d, i_ext_clock_in_c, i_ext_clock_in_b, i_ext_clock_in_a} <= 4'hA;
    i_phase_mode <= 2'h1;
    repeat (3) @(posedge i_ref_clk);
    #1;
    `CHK({o_phase_a, o_phase_b}, 4'h1)
  endtask
  task automatic wrap_up();
    if (err_count == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge i_ref_clk);
    i_rst <= 1'h0;
    @(posedge i_ref_clk);
    t_ch0();
    t_ch12();
    t_pins();
    wrap_up();
  end
endmodule // mcpt_event_pins_tb
